// >>> rtl/timer_pulse_capture_ppg_pkg.sv
// constants for the 16-bit capture / pulse generator timer channel
// assumes a single 100 MHz core clock and an AXI4-Lite register port
package timer_pulse_capture_ppg_pkg;
	// -------------------------------------------------------------------------
	// register offsets (byte addresses)
	// -------------------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_MODE = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;
	localparam logic [7:0] OFF_RA_LO = 8'h08;
	localparam logic [7:0] OFF_RA_HI = 8'h0C;
	localparam logic [7:0] OFF_RB_LO = 8'h10;
	localparam logic [7:0] OFF_RB_HI = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	// -------------------------------------------------------------------------
	// field positions
	// -------------------------------------------------------------------------
	localparam int MODE_SEL_LSB = 0;
	localparam int MODE_EDGE_BIT = 3;
	localparam int MODE_CAP_BIT = 4;
	localparam int MODE_CLK_LSB = 5;
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_OVE_BIT = 1;
	localparam int CTRL_SHOT_BIT = 2;
	localparam int CTRL_INIT_BIT = 3;
	localparam int CTRL_DBUF_BIT = 4;
	localparam int CTRL_FILT_LSB = 5;
	localparam int STAT_CPFA_BIT = 0;
	localparam int STAT_CPFB_BIT = 1;
	localparam int STAT_OVF_BIT = 2;
	// -------------------------------------------------------------------------
	// codes, reset values and timing
	// -------------------------------------------------------------------------
	localparam logic [2:0] MODE_PPG = 3'h3;
	localparam logic [2:0] MODE_PWM = 3'h6;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [1:0] FILT_OFF = 2'h0;
	localparam int FILT_DIV_FAST = 2;
	localparam int FILT_DIV_MID = 4;
	localparam int FILT_DIV_SLOW = 256;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {PW_WAIT, PW_HIGH, PW_LOW} pw_state_t;
endpackage : timer_pulse_capture_ppg_pkg

// >>> rtl/timer_pulse_capture_ppg.sv
// 16-bit timer channel: pulse width capture, pulse generator, input noise filter
// assumes pin input asynchronous, slow_tick_i a one-cycle enable from the core clock
//
// How it works
// - mode code 110 selects width capture; edge_polarity 1 picks falling start edge.
// - capture_style 0 gives double-edge capture, 1 gives single-edge capture.
// - overflow raises the interrupt only while overflow_irq_enable is set.
// - starting capture zeroes both registers; stopping clears the counter.
// - while running, mode and overflow enable ignore writes; idle level only while running in generator mode.
// - start edge interrupts and counts; opposite edge loads register_b, sets flag b.
// - double-edge: next start edge loads register_a, sets flag a, clears counter.
// - single-edge: opposite edge stops and clears counter until next start edge.
// - counter overflow during capture sets the overflow flag.
// - reading the status register clears all three flags.
// - mode code 011 selects pulse generation from period and first-toggle registers.
// - pulse output idles at out_init_level and returns there on any stop.
// - counter equal to register_b but not register_a drives the output to the opposite level.
// - counter equal to register_a restores the idle level and interrupts.
// - register_a match restarts counting, or stops the timer in one-shot.
// - double buffering holds running writes in a shadow until register_a match.
// - low byte waits in a temporary buffer until the high byte is written.
// - filter accepts a level after three equal samples; locked while running.
// - filter codes sample every 2, 4 or 256 clocks; slow mode rules apply.
`timescale 1ns/100ps
module timer_pulse_capture_ppg (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic slow_mode_i,
	input wire logic slow_tick_i,
	input wire logic cap_pin_i,
	output logic pulse_o,
	output logic irq_o,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [timer_pulse_capture_ppg_pkg::ADDR_W-1:0] awaddr_i,
	input wire logic wvalid_i,
	output logic wready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	output logic bvalid_o,
	input wire logic bready_i,
	output logic [1:0] bresp_o,
	input wire logic arvalid_i,
	output logic arready_o,
	input wire logic [timer_pulse_capture_ppg_pkg::ADDR_W-1:0] araddr_i,
	output logic rvalid_o,
	input wire logic rready_i,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o
);
	import timer_pulse_capture_ppg_pkg::*;

	// -------------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------------
	typedef struct packed {
		logic [2:0] mode;
		logic edge_pol;
		logic cap_style;
		logic [2:0] clk_sel;
		logic run;
		logic ove;
		logic shot;
		logic out_init;
		logic dbuf;
		logic [1:0] filt;
		logic [15:0] ra;
		logic [15:0] rb;
		logic [15:0] sha;
		logic [15:0] shb;
		logic [15:0] cnt;
		logic [7:0] tmp;
		logic [7:0] pre;
		logic [2:0] sync;
		logic pin_lvl;
		logic [1:0] smp;
		logic filt_out;
		logic prev_in;
		logic cpfa;
		logic cpfb;
		logic ovf;
		pw_state_t pw;
		logic irq;
		logic pout;
		logic awready;
		logic wready;
		logic aw_held;
		logic w_held;
		logic [ADDR_W-1:0] waddr;
		logic [7:0] wbyte;
		logic wlane;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_t;

	state_t st_q;
	state_t st_d;

	// -------------------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------------------
	// counter source tick: prescaler low sel bits all ones, i.e. every 2^sel clocks
	function automatic logic src_tick(input logic [2:0] sel, input logic [7:0] pre);
		logic [7:0] m;
		m = ~(8'hFF << sel);
		src_tick = (pre & m) == m;
	endfunction : src_tick

	// filter sample strobe from the shared prescaler, or from slow_tk for code 11 in slow mode
	function automatic logic smp_tick(input logic [1:0] code, input logic [7:0] pre,
		input logic slow, input logic slow_tk);
		unique case (code)
			2'h0: smp_tick = 1'b0;
			2'h1: smp_tick = !slow && pre[0:0] == 1'(FILT_DIV_FAST - 1);
			2'h2: smp_tick = !slow && pre[1:0] == 2'(FILT_DIV_MID - 1);
			2'h3: smp_tick = slow ? slow_tk : pre == 8'(FILT_DIV_SLOW - 1);
		endcase
	endfunction : smp_tick

	logic tick;
	logic rise;
	logic fall;
	logic start_e;
	logic opp_e;
	logic wr_go;
	logic [15:0] wr16;

	// edge detection on the filtered input
	assign tick = src_tick(st_q.clk_sel, st_q.pre);
	assign rise = st_q.filt_out & ~st_q.prev_in;
	assign fall = ~st_q.filt_out & st_q.prev_in;
	assign start_e = st_q.edge_pol ? fall : rise;
	assign opp_e = st_q.edge_pol ? rise : fall;
	assign wr_go = st_q.aw_held && st_q.w_held && !st_q.bvalid;
	assign wr16 = {st_q.wbyte, st_q.tmp};

	// -------------------------------------------------------------------------
	// next state
	// -------------------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.irq = 1'b0;
		st_d.pre = st_q.pre + 8'h01;
		// three-stage pin synchroniser, level accepted when stages two and three agree
		st_d.sync = {st_q.sync[1:0], cap_pin_i};
		if (st_q.sync[1] == st_q.sync[2]) begin
			st_d.pin_lvl = st_q.sync[2];
		end
		// noise filter, slow mode with codes 01/10 holds the input
		if (st_q.filt == FILT_OFF) begin
			st_d.filt_out = st_q.pin_lvl;
		end else if (smp_tick(st_q.filt, st_q.pre, slow_mode_i, slow_tick_i)) begin
			st_d.smp = {st_q.smp[0], st_q.pin_lvl};
			if (st_q.pin_lvl == st_q.smp[0] && st_q.smp[0] == st_q.smp[1]) begin
				st_d.filt_out = st_q.pin_lvl;
			end
		end
		st_d.prev_in = st_q.filt_out;

		// read channel; status read clears flags before new events set them
		if (st_q.rvalid && rready_i) begin
			st_d.rvalid = 1'b0;
		end
		if (arvalid_i && st_q.arready) begin
			st_d.rvalid = 1'b1;
			st_d.rresp = RESP_OKAY;
			st_d.rdata = 32'h0000_0000;
			unique case (araddr_i)
				OFF_MODE: st_d.rdata[7:0] = {st_q.clk_sel, st_q.cap_style, st_q.edge_pol, st_q.mode};
				OFF_CTRL: st_d.rdata[7:0] = {1'b0, st_q.filt, st_q.dbuf, st_q.out_init, st_q.shot,
					st_q.ove, st_q.run};
				OFF_RA_LO, OFF_RA_HI: st_d.rdata[15:0] =
					(st_q.dbuf && st_q.mode == MODE_PPG) ? st_q.sha : st_q.ra;
				OFF_RB_LO, OFF_RB_HI: st_d.rdata[15:0] =
					(st_q.dbuf && st_q.mode == MODE_PPG) ? st_q.shb : st_q.rb;
				OFF_STATUS: begin
					st_d.rdata[STAT_CPFA_BIT] = st_q.cpfa;
					st_d.rdata[STAT_CPFB_BIT] = st_q.cpfb;
					st_d.rdata[STAT_OVF_BIT] = st_q.ovf;
					st_d.cpfa = 1'b0;
					st_d.cpfb = 1'b0;
					st_d.ovf = 1'b0;
				end
				default: st_d.rresp = RESP_SLVERR;
			endcase
		end

		// pulse width measurement
		if (st_q.run && st_q.mode == MODE_PWM) begin
			if (tick && st_q.pw != PW_WAIT) begin
				st_d.cnt = st_q.cnt + 16'h0001;
				if (st_q.cnt == CNT_MAX) begin
					st_d.ovf = 1'b1;
					if (st_q.ove) begin
						st_d.irq = 1'b1;
					end
				end
			end
			unique case (st_q.pw)
				PW_WAIT: if (start_e) begin
					st_d.irq = 1'b1;
					st_d.cnt = CNT_ZERO;
					st_d.pw = PW_HIGH;
				end
				PW_HIGH: if (opp_e) begin
					st_d.rb = st_q.cnt;
					st_d.irq = 1'b1;
					st_d.cpfb = 1'b1;
					if (st_q.cap_style) begin
						st_d.cnt = CNT_ZERO;
						st_d.pw = PW_WAIT;
					end else begin
						st_d.pw = PW_LOW;
					end
				end
				PW_LOW: if (start_e) begin
					st_d.ra = st_q.cnt;
					st_d.irq = 1'b1;
					st_d.cpfa = 1'b1;
					st_d.cnt = CNT_ZERO;
					st_d.pw = PW_HIGH;
				end
				default: st_d.pw = PW_WAIT;
			endcase
		end else if (st_q.run && st_q.mode == MODE_PPG && tick) begin
			if (st_q.cnt == st_q.ra) begin
				st_d.pout = st_q.out_init;
				st_d.irq = 1'b1;
				st_d.cnt = CNT_ZERO;
				st_d.run = !st_q.shot;
				if (st_q.dbuf) begin
					st_d.ra = st_q.sha;
					st_d.rb = st_q.shb;
				end
			end else begin
				if (st_q.cnt == st_q.rb) begin
					st_d.pout = !st_q.out_init;
				end
				st_d.cnt = st_q.cnt + 16'h0001;
			end
		end
		// idle level whenever the generator is not running
		if (!st_q.run || st_q.mode != MODE_PPG) begin
			st_d.pout = st_q.out_init;
		end

		// write channel: address and data taken in either order
		if (awvalid_i && st_q.awready) begin
			st_d.aw_held = 1'b1;
			st_d.waddr = awaddr_i;
		end
		if (wvalid_i && st_q.wready) begin
			st_d.w_held = 1'b1;
			st_d.wbyte = wdata_i[7:0];
			st_d.wlane = wstrb_i[0];
		end
		if (st_q.bvalid && bready_i) begin
			st_d.bvalid = 1'b0;
		end
		if (wr_go) begin
			st_d.aw_held = 1'b0;
			st_d.w_held = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = RESP_OKAY;
			unique case (st_q.waddr)
				OFF_MODE: if (st_q.wlane && !st_q.run) begin
					st_d.mode = st_q.wbyte[MODE_SEL_LSB +: 3];
					st_d.edge_pol = st_q.wbyte[MODE_EDGE_BIT];
					st_d.cap_style = st_q.wbyte[MODE_CAP_BIT];
					st_d.clk_sel = st_q.wbyte[MODE_CLK_LSB +: 3];
				end
				OFF_CTRL: if (st_q.wlane) begin
					st_d.shot = st_q.wbyte[CTRL_SHOT_BIT];
					st_d.dbuf = st_q.wbyte[CTRL_DBUF_BIT];
					st_d.run = st_q.wbyte[CTRL_RUN_BIT];
					if (!st_q.run) begin
						st_d.ove = st_q.wbyte[CTRL_OVE_BIT];
						st_d.filt = st_q.wbyte[CTRL_FILT_LSB +: 2];
					end
					if (!(st_q.run && st_q.mode == MODE_PPG)) begin
						st_d.out_init = st_q.wbyte[CTRL_INIT_BIT];
					end
					if (st_q.wbyte[CTRL_RUN_BIT] != st_q.run) begin
						st_d.cnt = CNT_ZERO;
						st_d.pw = PW_WAIT;
						if (!st_q.run && st_q.mode == MODE_PWM) begin
							st_d.ra = CNT_ZERO;
							st_d.rb = CNT_ZERO;
						end
					end
				end
				OFF_RA_LO, OFF_RB_LO: if (st_q.wlane) begin
					st_d.tmp = st_q.wbyte;
				end
				OFF_RA_HI: if (st_q.wlane) begin
					st_d.sha = wr16;
					if (!(st_q.dbuf && st_q.run)) begin
						st_d.ra = wr16;
					end
				end
				OFF_RB_HI: if (st_q.wlane) begin
					st_d.shb = wr16;
					if (!(st_q.dbuf && st_q.run)) begin
						st_d.rb = wr16;
					end
				end
				OFF_STATUS: ;
				default: st_d.bresp = RESP_SLVERR;
			endcase
		end
		st_d.awready = !st_d.aw_held && !st_d.bvalid;
		st_d.wready = !st_d.w_held && !st_d.bvalid;
		st_d.arready = !st_d.rvalid;
	end

	// state register
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from the state flops
	assign pulse_o = st_q.pout;
	assign irq_o = st_q.irq;
	assign awready_o = st_q.awready;
	assign wready_o = st_q.wready;
	assign bvalid_o = st_q.bvalid;
	assign bresp_o = st_q.bresp;
	assign arready_o = st_q.arready;
	assign rvalid_o = st_q.rvalid;
	assign rdata_o = st_q.rdata;
	assign rresp_o = st_q.rresp;

	// -------------------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	sequence s_ppg_tick;
		st_q.run && st_q.mode == MODE_PPG && tick && !wr_go;
	endsequence
	sequence s_ppg_a_hit;
		s_ppg_tick ##0 st_q.cnt == st_q.ra;
	endsequence
	sequence s_pw_run;
		st_q.run && st_q.mode == MODE_PWM && !wr_go;
	endsequence

	a_pw_init_zero: assert property ($rose(st_q.run) && st_q.mode == MODE_PWM
		|-> st_q.ra == 16'h0000 && st_q.rb == 16'h0000) else $error("registers not zeroed");
	a_stop_clears: assert property ($fell(st_q.run) |-> st_q.cnt == 16'h0000)
		else $error("counter not cleared on stop");
	a_mode_lock: assert property ($past(st_q.run) |-> $stable(st_q.mode))
		else $error("mode changed while running");
	a_capture_b: assert property (s_pw_run ##0 st_q.pw == PW_HIGH && opp_e
		|=> st_q.rb == $past(st_q.cnt) && st_q.cpfb && irq_o) else $error("capture b wrong");
	a_capture_a: assert property (s_pw_run ##0 st_q.pw == PW_LOW && start_e
		|=> st_q.ra == $past(st_q.cnt) && st_q.cpfa && st_q.cnt == 16'h0000)
		else $error("capture a wrong");
	a_single_stop: assert property (s_pw_run ##0 st_q.pw == PW_HIGH && opp_e
		&& st_q.cap_style |=> st_q.pw == PW_WAIT && st_q.cnt == 16'h0000)
		else $error("single edge no stop");
	a_ovf_flag: assert property (s_pw_run ##0 st_q.pw != PW_WAIT && tick
		&& st_q.cnt == 16'hFFFF |=> st_q.ovf) else $error("overflow flag missed");
	a_ppg_b_level: assert property (s_ppg_tick ##0 st_q.cnt == st_q.rb
		&& st_q.cnt != st_q.ra |=> pulse_o == !$past(st_q.out_init)) else $error("b match level");
	a_ppg_a_level: assert property (s_ppg_a_hit
		|=> pulse_o == $past(st_q.out_init) && irq_o) else $error("a match level or irq");
	a_one_shot: assert property (s_ppg_a_hit ##0 st_q.shot |=> !st_q.run)
		else $error("one-shot did not stop");
	a_idle_level: assert property (!$past(st_q.run) |-> pulse_o == $past(st_q.out_init))
		else $error("idle level wrong");
endmodule : timer_pulse_capture_ppg

// >>> tb/pulse_source.sv
// pulse source for the timer input pin and width meter for the generator pin
// assumes the bench clock runs freely; the input pin idles low outside bursts
`timescale 1ns/100ps
module pulse_source (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [16:0] hi_len_i,
	input wire logic [16:0] lo_len_i,
	input wire logic [1:0] count_i,
	input wire logic ppg_i,
	output logic pin_o,
	output logic busy_o,
	output logic [15:0] width_o
);
	logic [15:0] run_q = 16'h0000;
	// -------------------------------------------------------------------------
	// burst of high pulses, each followed by a low gap
	// -------------------------------------------------------------------------
	initial begin
		pin_o = 1'b0;
		busy_o = 1'b0;
		forever begin
			@(posedge clk_i);
			if (go_i) begin
				busy_o <= 1'b1;
				repeat (count_i) begin
					pin_o <= 1'b1;
					repeat (hi_len_i) @(posedge clk_i);
					pin_o <= 1'b0;
					repeat (lo_len_i) @(posedge clk_i);
				end
				busy_o <= 1'b0;
			end
		end
	end
	// high time of the last generator pulse
	always @(posedge clk_i) begin
		if (ppg_i === 1'b1) begin
			run_q <= run_q + 16'h0001;
		end else if (run_q != 16'h0000) begin
			width_o <= run_q;
			run_q <= 16'h0000;
		end
	end
endmodule : pulse_source

// >>> tb/testbench.sv
// self-checking bench: register table, width capture, generator, filter
// assumes the pulse source drives the input pin and meters the output pin
`timescale 1ns/100ps
module testbench;
	import timer_pulse_capture_ppg_pkg::*;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_t;
	logic clk, reset, pin, pulse, irq, go, busy, awvalid, awready, wvalid, wready;
	logic bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_v;
	logic [1:0] bresp, rresp, rd_r, n_p;
	logic [16:0] hi_len, lo_len;
	logic [15:0] width;
	int err_total = 0, n_compared = 0, cyc = 0, irq_cnt = 0, last_irq = 0, gap = 0;
	int dbl = 0, n0;
	logic irq_q = 1'b0;
	logic slow = 1'b0, stick = 1'b0;
	row_t rows [11];

	timer_pulse_capture_ppg timer_pulse_capture_ppg_i (.core_clk_i(clk), .reset_i(reset),
		.slow_mode_i(slow), .slow_tick_i(stick), .cap_pin_i(pin), .pulse_o(pulse),
		.irq_o(irq), .awvalid_i(awvalid), .awready_o(awready), .awaddr_i(awaddr),
		.wvalid_i(wvalid), .wready_o(wready), .wdata_i(wdata), .wstrb_i(4'h1),
		.bvalid_o(bvalid), .bready_i(bready), .bresp_o(bresp), .arvalid_i(arvalid),
		.arready_o(arready), .araddr_i(araddr), .rvalid_o(rvalid), .rready_i(rready),
		.rdata_o(rdata), .rresp_o(rresp));
	pulse_source pulse_source_i (.clk_i(clk), .go_i(go), .hi_len_i(hi_len),
		.lo_len_i(lo_len), .count_i(n_p), .ppg_i(pulse), .pin_o(pin), .busy_o(busy),
		.width_o(width));

	// -------------------------------------------------------------------------
	// clock, interrupt monitor and watchdog
	// -------------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		irq_q <= irq;
		stick <= cyc[1:0] == 2'h3; // slow-clock enable, one cycle in four
		if (irq === 1'b1) begin
			irq_cnt <= irq_cnt + 1;
			gap <= cyc - last_irq;
			last_irq <= cyc;
		end
		if (irq === 1'b1 && irq_q === 1'b1) dbl <= dbl + 1;
		if (cyc == 90000) begin
			err_total++;
			conclude();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rd_r = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd_v = rdata;
		rd_r = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask : rd
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(nm, rd_v, e);
	endtask : rchk
	// burst on the input pin, then let the synchroniser drain
	task automatic burst(input int h, input int l, input int n);
		n0 = irq_cnt;
		hi_len <= h[16:0];
		lo_len <= l[16:0];
		n_p <= n[1:0];
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 70000 && busy; i++) @(posedge clk);
		repeat (12) @(posedge clk);
	endtask : burst
	task automatic wait_irqs(input int n);
		int t;
		t = irq_cnt + n;
		for (int i = 0; i < 500 && irq_cnt < t; i++) @(posedge clk);
	endtask : wait_irqs
	task automatic conclude();
		$display("errors %0d compared %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : conclude

	// -------------------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------------------
	initial begin
		{reset, go, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
		{awaddr, araddr, wdata} = 48'h0;
		rows[0] = {1'b0, OFF_MODE, 32'h0, RESP_OKAY};
		rows[1] = {1'b0, OFF_CTRL, 32'h0, RESP_OKAY};
		rows[2] = {1'b0, OFF_STATUS, 32'h0, RESP_OKAY};
		rows[3] = {1'b0, 8'h1C, 32'h0, RESP_SLVERR};
		rows[4] = {1'b1, 8'h1C, 32'h5, RESP_SLVERR};
		rows[5] = {1'b1, OFF_MODE, 32'h16, RESP_OKAY};
		rows[6] = {1'b0, OFF_MODE, 32'h16, RESP_OKAY};
		rows[7] = {1'b1, OFF_RA_LO, 32'h34, RESP_OKAY};
		rows[8] = {1'b0, OFF_RA_LO, 32'h0, RESP_OKAY};
		rows[9] = {1'b1, OFF_RA_HI, 32'h12, RESP_OKAY};
		rows[10] = {1'b0, OFF_RA_HI, 32'h1234, RESP_OKAY};
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			else rd(rows[i].a);
			if (!rows[i].w) chk("rdata", rd_v, rows[i].d);
			chk("resp", rd_r, rows[i].r);
		end
		// double-edge capture, rising start
		wr(OFF_MODE, 32'h06);
		wr(OFF_CTRL, 32'h01);
		rchk("a cleared", OFF_RA_LO, 32'h0);
		wr(OFF_MODE, 32'h03);
		rchk("mode lock", OFF_MODE, 32'h06);
		wr(OFF_CTRL, 32'h03);
		rchk("ove lock", OFF_CTRL, 32'h01);
		burst(20, 30, 2);
		chk("irqs", irq_cnt - n0, 4);
		rchk("status", OFF_STATUS, 32'h3);
		rchk("status clr", OFF_STATUS, 32'h0);
		rd(OFF_RB_LO);
		chk("b width", 32'(rd_v >= 19 && rd_v <= 21), 1);
		rd(OFF_RA_HI);
		chk("a period", 32'(rd_v >= 49 && rd_v <= 51), 1);
		// single-edge, falling start: first rising edge ignored
		wr(OFF_CTRL, 32'h0);
		wr(OFF_MODE, 32'h1E);
		wr(OFF_CTRL, 32'h01);
		burst(20, 30, 2);
		chk("irqs", irq_cnt - n0, 3);
		rchk("status", OFF_STATUS, 32'h2);
		rd(OFF_RB_HI);
		chk("b width", 32'(rd_v >= 29 && rd_v <= 31), 1);
		// overflow during capture with interrupt enabled
		wr(OFF_CTRL, 32'h0);
		wr(OFF_MODE, 32'h06);
		wr(OFF_CTRL, 32'h03);
		burst(66000, 10, 1);
		chk("irqs", irq_cnt - n0, 3);
		rchk("status", OFF_STATUS, 32'h6);
		// input filter at 2-clock sampling
		wr(OFF_CTRL, 32'h0);
		wr(OFF_MODE, 32'h16);
		wr(OFF_CTRL, 32'h20);
		repeat (8) @(posedge clk);
		wr(OFF_CTRL, 32'h21);
		wr(OFF_CTRL, 32'h61);
		rchk("filter lock", OFF_CTRL, 32'h21);
		burst(3, 20, 1);
		chk("glitch", irq_cnt - n0, 0);
		burst(12, 20, 1);
		chk("pulse", irq_cnt - n0, 2);
		// generator, double buffered, continuous then one-shot
		wr(OFF_CTRL, 32'h0);
		wr(OFF_MODE, 32'h03);
		wr(OFF_RA_LO, 32'h04);
		wr(OFF_RA_HI, 32'h00);
		wr(OFF_RB_LO, 32'h02);
		wr(OFF_RB_HI, 32'h00);
		wr(OFF_CTRL, 32'h11);
		wait_irqs(3);
		chk("period", gap, 5);
		chk("high", width, 2);
		wr(OFF_CTRL, 32'h19);
		rchk("init lock", OFF_CTRL, 32'h11);
		wr(OFF_RA_LO, 32'h06);
		wr(OFF_RA_HI, 32'h00);
		rchk("shadow", OFF_RA_LO, 32'h6);
		wait_irqs(3);
		chk("period", gap, 7);
		chk("high", width, 4);
		wr(OFF_CTRL, 32'h15);
		wait_irqs(1);
		rchk("shot stop", OFF_CTRL, 32'h14);
		chk("idle", pulse, 0);
		wr(OFF_CTRL, 32'h08);
		chk("idle", pulse, 1);
		n0 = irq_cnt;
		wr(OFF_CTRL, 32'h0D);
		wait_irqs(1);
		rchk("one shot", OFF_CTRL, 32'h0C);
		chk("idle", pulse, 1);
		chk("irqs", irq_cnt - n0, 1);
		// slower source clock: one count every two clocks
		wr(OFF_MODE, 32'h23);
		wr(OFF_CTRL, 32'h01);
		wait_irqs(3);
		chk("div period", gap, 14);
		chk("div high", width, 8);
		wr(OFF_CTRL, 32'h0);
		// slow clock mode: code 01 blocks the pin, code 11 samples on the slow tick
		wr(OFF_MODE, 32'h16);
		slow <= 1'b1;
		wr(OFF_CTRL, 32'h20);
		wr(OFF_CTRL, 32'h21);
		burst(12, 20, 1);
		chk("slow block", irq_cnt - n0, 0);
		wr(OFF_CTRL, 32'h0);
		wr(OFF_CTRL, 32'h60);
		repeat (40) @(posedge clk);
		wr(OFF_CTRL, 32'h61);
		burst(40, 40, 1);
		chk("slow pulse", irq_cnt - n0, 2);
		slow <= 1'b0;
		// reset in mid-run returns the registers and the pin to zero
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk("reset pin", pulse, 0);
		rchk("reset ctrl", OFF_CTRL, 32'h0);
		rchk("reset mode", OFF_MODE, 32'h0);
		chk("irq width", dbl, 0);
		conclude();
	end
endmodule : testbench
